// File: src/pwc_wave_counter.sv
// Purpose: Four-channel pulse width wave counter with an APB register port
// Assumes: Decoder presents one set of RAM entries with dec_valid; APB with
//          one registered wait state
// Notes:   Compare values are internal and follow the decoder only
// What this block does
// - One shared 15-bit counter, four channels
// - Polarity comes from each RAM entry
// - Control bit picks up or up-down count
// - Top register and divider set period
// - Top below compare gives no edges
// - Compare registers loaded only by decoder
// - Top sampled on tasks and RAM loads
// - Arbitrary layout takes top from RAM
// - Up mode wraps to zero at top
// - Compare zero low, compare top high in up mode
// - Up period is tick times top
// - Up-down counts back, center-aligned pulses
// - Up-down period is two times top ticks
// - Glitch-free reload at period ends with dec_valid, not while stopping
// - Entry bit 15 polarity, bits 14:0 compare
// - Stop ends period, event, idle outputs
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "pwc_regs.svh"
module pwc_wave_counter
   import pwc_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        dec_valid,
   input  wire pwc_set_t    dec_set,
   output logic             dec_take,
   input  wire logic [3:0]  idle_level,
   output logic [3:0]       pwm_out,
   output logic             period_end,
   output logic             stopped_evt
);
   logic [4:0]  ctrl_reg, ctrl_next;
   logic [14:0] top_reg, top_next;
   logic        stopped_reg, stopped_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   pwc_state_t  st_reg, st_next;
   logic [14:0] cnt_reg, cnt_next;
   logic        down_reg, down_next;
   logic [14:0] act_top_reg, act_top_next;
   pwc_set_t    ent_reg, ent_next;
   logic [3:0]  out_reg, out_next;
   logic        pe_reg, pe_next;
   logic        stev_reg, stev_next;
   logic        take_reg, take_next;
   logic        acc, wr, t_start, t_seq, t_stop, go, tick, pe, load, running, arb, ud;

   // Falling-first starts high and drops once the count reaches the compare
   function automatic logic level(input logic [14:0] c, input pwc_entry_t e);
      level = e.pol ? (c < e.cmp) : !(c < e.cmp);
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   assign acc     = psel && penable && pready_reg;
   assign wr      = acc && pwrite;
   assign t_start = wr && hit(paddr, `PWC_OFS_TASK) && pwdata[`PWC_TASK_START];
   assign t_seq   = wr && hit(paddr, `PWC_OFS_TASK) && pwdata[`PWC_TASK_SEQ];
   assign t_stop  = wr && hit(paddr, `PWC_OFS_TASK) && pwdata[`PWC_TASK_STOP];
   assign go      = t_start || t_seq;
   assign running = (st_reg != ST_IDLE);
   assign arb     = ctrl_reg[`PWC_CTRL_ARB];
   assign ud      = ctrl_reg[`PWC_CTRL_UPDOWN];

   pwc_prescaler u_pre (
      .ref_clk (ref_clk),
      .reset   (reset),
      .run     (running),
      .clr     (go),
      .pre     (ctrl_reg[`PWC_CTRL_PRE_HI:`PWC_CTRL_PRE_LO]),
      .tick    (tick)
   );

   // APB slave: one wait state, reads captured on the first access cycle
   always_comb begin
      ctrl_next    = ctrl_reg;
      top_next     = top_reg;
      prdata_next  = prdata_reg;
      pslverr_next = pslverr_reg;
      pready_next  = psel && penable && !pready_reg;
      stopped_next = stopped_reg;
      if (wr && hit(paddr, `PWC_OFS_CTRL)) begin
         ctrl_next = pwdata[4:0];
      end
      if (wr && hit(paddr, `PWC_OFS_TOP)) begin
         top_next = pwdata[14:0];
      end
      if (wr && hit(paddr, `PWC_OFS_STATUS) && pwdata[`PWC_STAT_STOPPED]) begin
         stopped_next = 1'b0;
      end
      // Hardware set wins over a software clear in the same cycle
      if (stev_next) begin
         stopped_next = 1'b1;
      end
      if (psel && penable && !pready_reg) begin
         prdata_next  = 32'h0000_0000;
         pslverr_next = 1'b0;
         if (hit(paddr, `PWC_OFS_CTRL)) begin
            prdata_next[4:0] = ctrl_reg;
         end else if (hit(paddr, `PWC_OFS_TOP)) begin
            prdata_next[14:0] = top_reg;
         end else if (hit(paddr, `PWC_OFS_TASK)) begin
            prdata_next = 32'h0000_0000;
         end else if (hit(paddr, `PWC_OFS_STATUS)) begin
            prdata_next[`PWC_STAT_RUN]      = running;
            prdata_next[`PWC_STAT_STOPPED]  = stopped_reg;
            prdata_next[`PWC_STAT_STOPPING] = (st_reg == ST_STOP);
         end else if (hit(paddr, `PWC_OFS_COUNT)) begin
            prdata_next[14:0] = cnt_reg;
         end else begin
            pslverr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_reg    <= `PWC_RST_CTRL;
         top_reg     <= `PWC_RST_TOP;
         stopped_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         top_reg     <= top_next;
         stopped_reg <= stopped_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Period end: up mode wraps after top ticks, up-down after two times top
   always_comb begin
      if (ud) begin
         pe = tick && ((down_reg && cnt_reg == 15'h0001) || act_top_reg == 15'h0000);
      end else begin
         pe = tick && (16'(cnt_reg) + 16'h0001 >= 16'(act_top_reg));
      end
   end

   // New entries only at a task or a period boundary, so no half-period glitches
   assign load = dec_valid && (go || (running && pe && st_reg != ST_STOP));

   always_comb begin
      st_next      = st_reg;
      cnt_next     = cnt_reg;
      down_next    = down_reg;
      act_top_next = act_top_reg;
      ent_next     = ent_reg;
      stev_next    = 1'b0;
      pe_next      = running && pe;
      take_next    = load;
      if (go) begin
         st_next   = ST_RUN;
         cnt_next  = 15'h0000;
         down_next = 1'b0;
         if (!arb) begin
            act_top_next = top_reg;
         end
      end else if (running && tick) begin
         if (!ud || act_top_reg == 15'h0000) begin
            cnt_next  = pe ? 15'h0000 : cnt_reg + 15'h0001;
            down_next = 1'b0;
         end else if (!down_reg) begin
            cnt_next  = cnt_reg + 15'h0001;
            down_next = (cnt_reg + 15'h0001 >= act_top_reg);
         end else begin
            cnt_next  = cnt_reg - 15'h0001;
            down_next = !pe;
         end
         if (pe && st_reg == ST_STOP) begin
            st_next   = ST_IDLE;
            stev_next = 1'b1;
            cnt_next  = 15'h0000;
            down_next = 1'b0;
         end
      end
      if (t_stop && !go && running) begin
         st_next = (st_reg == ST_STOP && pe) ? ST_IDLE : ST_STOP;
         if (st_next == ST_IDLE) begin
            stev_next = 1'b1;
         end
      end else if (t_stop && !go) begin
         stev_next = 1'b1;
      end
      if (load) begin
         ent_next = dec_set;
         if (arb) begin
            act_top_next = dec_set[3].cmp;
         end else begin
            act_top_next = top_reg;
         end
      end
   end

   // Outputs come from the next count, so count and entry changes move the pin only on a tick or a task
   always_comb begin
      out_next = idle_level;
      if (st_next != ST_IDLE) begin
         for (int i = 0; i < 4; i++) begin
            out_next[i] = level(cnt_next, ent_next[i]);
         end
         if (arb) begin
            out_next[3] = idle_level[3];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_reg      <= ST_IDLE;
         cnt_reg     <= 15'h0000;
         down_reg    <= 1'b0;
         act_top_reg <= `PWC_RST_TOP;
         ent_reg     <= '0;
         out_reg     <= 4'h0;
         pe_reg      <= 1'b0;
         stev_reg    <= 1'b0;
         take_reg    <= 1'b0;
      end else begin
         st_reg      <= st_next;
         cnt_reg     <= cnt_next;
         down_reg    <= down_next;
         act_top_reg <= act_top_next;
         ent_reg     <= ent_next;
         out_reg     <= out_next;
         pe_reg      <= pe_next;
         stev_reg    <= stev_next;
         take_reg    <= take_next;
      end
   end

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign pwm_out     = out_reg;
   assign period_end  = pe_reg;
   assign stopped_evt = stev_reg;
   assign dec_take    = take_reg;

   property p_up_wrap;
      @(posedge ref_clk) disable iff (reset)
      (st_reg == ST_RUN && !ud && pe && !go && !load) |=> (cnt_reg == 15'h0000);
   endproperty
   a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap");

   property p_up_bound;
      @(posedge ref_clk) disable iff (reset)
      // A count left at top by a switch out of up-down mode is still falling
      (running && !ud && !down_reg && act_top_reg != 15'h0000 && $stable(act_top_reg))
         |-> (cnt_reg < act_top_reg);
   endproperty
   a_up_bound: assert property (p_up_bound) else $error("count above top");

   property p_ud_down;
      @(posedge ref_clk) disable iff (reset)
      (st_reg == ST_RUN && ud && tick && down_reg && cnt_reg > 15'h0001 && !go)
         |=> (cnt_reg == $past(cnt_reg) - 15'h0001);
   endproperty
   a_ud_down: assert property (p_ud_down) else $error("up-down count not falling");

   property p_zero_low;
      @(posedge ref_clk) disable iff (reset)
      (running && $past(running) && !arb && ent_reg[0].pol && ent_reg[0].cmp == 15'h0000)
         |-> !pwm_out[0];
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("zero compare not low");

   property p_above_top;
      @(posedge ref_clk) disable iff (reset)
      (running && $past(running) && !arb && !$past(arb) && ent_reg[3].pol
         && ent_reg[3].cmp > act_top_reg) |-> pwm_out[3];
   endproperty
   a_above_top: assert property (p_above_top) else $error("edge with compare above top");

   property p_cmp_hold;
      @(posedge ref_clk) disable iff (reset)
      !load |=> $stable(ent_reg);
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed without load");

   property p_arb_top;
      @(posedge ref_clk) disable iff (reset)
      (load && arb) |=> (act_top_reg == $past(dec_set[3].cmp));
   endproperty
   a_arb_top: assert property (p_arb_top) else $error("top not taken from entry");

   property p_task_top;
      @(posedge ref_clk) disable iff (reset)
      (go && !arb) |=> (act_top_reg == $past(top_reg));
   endproperty
   a_task_top: assert property (p_task_top) else $error("top not sampled on task");

   property p_stop_idle;
      @(posedge ref_clk) disable iff (reset)
      (st_reg == ST_STOP && pe && !go) |=> (stopped_evt && st_reg == ST_IDLE
         && pwm_out == $past(idle_level));
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not end period");

   property p_out_on_tick;
      @(posedge ref_clk) disable iff (reset)
      (st_reg == ST_RUN && $past(st_reg) == ST_RUN && !$past(go) && !$past(load)
         && $past(idle_level) == $past(idle_level, 2) && $past(ctrl_reg) == $past(ctrl_reg, 2)
         && pwm_out != $past(pwm_out)) |-> $past(tick);
   endproperty
   a_out_on_tick: assert property (p_out_on_tick) else $error("output moved off tick");
endmodule

// File: src/pwc_regs.svh
// Purpose: Register map, field positions and reset values of the wave counter
// Assumes: APB, 32-bit data, one word per register
// Notes:   Included by the main module and the bench
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_OFS_CTRL       12'h000
`define PWC_OFS_TOP        12'h004
`define PWC_OFS_TASK       12'h008
`define PWC_OFS_STATUS     12'h00c
`define PWC_OFS_COUNT      12'h010

`define PWC_CTRL_UPDOWN    0
`define PWC_CTRL_ARB       1
`define PWC_CTRL_PRE_LO    2
`define PWC_CTRL_PRE_HI    4

`define PWC_TASK_START     0
`define PWC_TASK_SEQ       1
`define PWC_TASK_STOP      2

`define PWC_STAT_RUN       0
`define PWC_STAT_STOPPED   1
`define PWC_STAT_STOPPING  2

`define PWC_RST_CTRL       5'h00
`define PWC_RST_TOP        15'h3e80

`endif

// File: src/pwc_pkg.sv
// Purpose: Types shared by the wave counter files
// Assumes: Nothing beyond SystemVerilog
// Notes:   One RAM entry holds a polarity bit over a 15-bit compare value
package pwc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_STOP
   } pwc_state_t;

   // Polarity high means the output starts high and falls at the compare point
   typedef struct packed {
      logic        pol;
      logic [14:0] cmp;
   } pwc_entry_t;

   typedef pwc_entry_t [3:0] pwc_set_t;

endpackage

// File: src/pwc_prescaler.sv
// Purpose: Divided clock tick for the wave counter
// Assumes: Divide ratio is two to the power of pre, 1 to 128
// Notes:   Cleared on restart so a period always begins on a full tick
`timescale 1ns/1ns
module pwc_prescaler (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       run,
   input  wire logic       clr,
   input  wire logic [2:0] pre,
   output logic            tick
);
   logic [6:0] div_reg;
   logic [6:0] div_next;
   logic       tick_reg;
   logic       tick_next;
   logic [6:0] last;

   always_comb begin
      last      = 7'((8'h01 << pre) - 8'h01);
      div_next  = div_reg;
      tick_next = 1'b0;
      if (clr || !run) begin
         div_next = 7'h00;
      end else if (div_reg >= last) begin
         div_next  = 7'h00;
         tick_next = 1'b1;
      end else begin
         div_next = div_reg + 7'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_reg  <= 7'h00;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// File: bench/pwc_gpio_model.sv
// Purpose: GPIO pin observer for the four channel outputs
// Assumes: period_end pulses once per period, one period apart
// Notes:   Any window one period long holds the same high time,
//          so the pulse offset does not matter
`timescale 1ns/1ns
module pwc_gpio_model (
   input  wire logic        ref_clk,
   input  wire logic [3:0]  pwm_out,
   input  wire logic        period_end,
   output logic [3:0][15:0] hi_cnt,
   output logic [15:0]      per_len
);
   logic [3:0][15:0] acc;
   logic [15:0]      len;

   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (period_end) begin
            hi_cnt[i] <= acc[i];
            acc[i]    <= 16'(pwm_out[i]);
         end else begin
            acc[i] <= acc[i] + 16'(pwm_out[i]);
         end
      end
      if (period_end) begin
         per_len <= len;
         len     <= 16'h1;
      end else begin
         len <= len + 16'h1;
      end
   end
endmodule

// File: bench/pwm_wave_counter_tb.sv
// Purpose: Self-checking bench for the wave counter
// Assumes: Registers reached over APB, decoder sets driven here
// Notes:   Duty and period are measured by the pin observer
`timescale 1ns/1ns
`include "pwc_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pwm_wave_counter_tb;
   import pwc_pkg::*;
   logic             ref_clk, reset, psel, penable, pwrite, dec_valid;
   logic             pready, pslverr, dec_take, period_end, stopped_evt, er;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic [3:0]       idle_level, pwm_out;
   pwc_set_t         dec_set, s;
   logic [3:0][15:0] hi_cnt;
   logic [15:0]      per_len;
   int               fails, compares, t, c, pre, k;

   pwc_wave_counter uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dec_valid(dec_valid), .dec_set(dec_set), .dec_take(dec_take),
      .idle_level(idle_level), .pwm_out(pwm_out), .period_end(period_end),
      .stopped_evt(stopped_evt));
   pwc_gpio_model pins (.ref_clk(ref_clk), .pwm_out(pwm_out), .period_end(period_end),
      .hi_cnt(hi_cnt), .per_len(per_len));

   function automatic pwc_entry_t ent(input logic p, input int v);
      ent.pol = p;
      ent.cmp = v[14:0];
   endfunction

   // Falling-first output is high while the count is below the compare value
   function automatic int exp_hi(input int v, input int top, input int p);
      return ((v > top) ? top : v) << p;
   endfunction

   task end_of_test;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // An edge passes first so a release is never followed by a request in one step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(rd, x)
   endtask

   task wait_pe(input int n);
      int m;
      repeat (n) begin
         m = 0;
         do begin @(posedge ref_clk); m++; end while (period_end !== 1'b1 && m < 3000);
         if (m >= 3000) fails++;
      end
   endtask

   // A task word of zero skips the task write and leaves the load to the next period end
   task load(input pwc_set_t v, input logic [31:0] tb);
      int m;
      @(posedge ref_clk);
      dec_set <= v; dec_valid <= 1'b1;
      if (tb != 0) apb(1'b1, `PWC_OFS_TASK, tb);
      m = 0;
      do begin @(posedge ref_clk); m++; end while (dec_take !== 1'b1 && m < 3000);
      if (m >= 3000) fails++;
      dec_valid <= 1'b0;
      wait_pe(2);
      // The observer latches at the pulse edge, so its counts settle one edge later
      @(posedge ref_clk);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      end_of_test;
   end

   initial begin
      reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; dec_valid = 1'b0; dec_set = '0; idle_level = 4'ha;
      fails = 0; compares = 0;
      k = $urandom(51875);
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK(pwm_out, idle_level)
      rdc(`PWC_OFS_TOP, 32'h3e80);
      rdc(`PWC_OFS_CTRL, 32'h0);
      apb(1'b1, 12'h3fc, 32'hffff);
      `CHK(er, 1'b1)
      pre = $urandom_range(2, 0);
      apb(1'b1, `PWC_OFS_CTRL, 32'(pre << 2));
      for (int n = 0; n < 2; n++) begin
         t = $urandom_range(40, 8);
         c = $urandom_range(t - 1, 1);
         apb(1'b1, `PWC_OFS_TOP, 32'(t));
         s = {ent(1'b1, t + 5), ent(1'b1, c), ent(1'b1, t), ent(1'b1, 0)};
         load(s, (n == 0) ? 32'h1 : 32'h0);
         `CHK(per_len, 16'(t << pre))
         for (int i = 0; i < 4; i++) `CHK(hi_cnt[i], 16'(exp_hi(s[i].cmp, t, pre)))
      end
      apb(1'b1, `PWC_OFS_CTRL, 32'((pre << 2) | 1));
      s = {ent(1'b1, t + 3), ent(1'b1, 0), ent(1'b0, c), ent(1'b1, c)};
      load(s, 32'h2);
      `CHK(per_len, 16'((2 * t) << pre))
      `CHK(16'(hi_cnt[0] + hi_cnt[1]), per_len)
      `CHK(hi_cnt[2], 16'h0)
      `CHK(hi_cnt[3], per_len)
      k = $urandom_range(40, 8);
      c = $urandom_range(k - 1, 1);
      apb(1'b1, `PWC_OFS_CTRL, 32'((pre << 2) | 2));
      s = {ent(1'b0, k), ent(1'b1, c), ent(1'b1, 0), ent(1'b1, k)};
      load(s, 32'h1);
      `CHK(per_len, 16'(k << pre))
      `CHK(hi_cnt[2], 16'(exp_hi(c, k, pre)))
      `CHK(hi_cnt[0], per_len)
      `CHK(hi_cnt[1], 16'h0)
      `CHK(hi_cnt[3], per_len)
      idle_level <= 4'h5;
      apb(1'b1, `PWC_OFS_TASK, 32'h4);
      k = 0;
      do begin @(posedge ref_clk); k++; end while (stopped_evt !== 1'b1 && k < 3000);
      `CHK(k < 3000, 1'b1)
      repeat (2) @(posedge ref_clk);
      `CHK(pwm_out, 4'h5)
      rdc(`PWC_OFS_STATUS, 32'h2);
      apb(1'b1, `PWC_OFS_STATUS, 32'h2);
      rdc(`PWC_OFS_STATUS, 32'h0);
      rdc(`PWC_OFS_COUNT, 32'h0);
      end_of_test;
   end
endmodule
